// file: src/bimg_pkg.sv
package bimg_pkg;
    localparam int NUM_INTX = 4;
    localparam int NUM_GPIO = 4;
    localparam int NUM_VEC = 8;
    localparam int SRC_W = 3;
    localparam int MSI_WIN_BYTES = 256;
    localparam int MSI_ADDR_W = 8;
    // register offsets (byte addresses, one word each)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_MSI_MASK = 8'h04;
    localparam logic [7:0] REG_VEC_MAP = 8'h08;
    localparam logic [7:0] REG_MSI_ADDR = 8'h0C;
    localparam logic [7:0] REG_MSI_DATA = 8'h10;
    localparam logic [7:0] REG_PIN_STAT = 8'h14;
    localparam logic [7:0] REG_IRQ_STAT = 8'h18;
    localparam logic [7:0] REG_IRQ_MASK = 8'h1C;
    localparam logic [7:0] REG_REQ_ID = 8'h20;
    // ctrl fields
    localparam int CTRL_INTX_MSI = 0;
    localparam int CTRL_GPIO_LSB = 4;
    // irq status bits
    localparam int IRQ_MSG_SENT = 0;
    localparam int IRQ_MSI_DROP = 1;
    localparam int IRQ_W = 2;
    // reset values
    localparam logic [31:0] RST_CTRL = 32'h0000_0000;
    localparam logic [7:0] RST_MSI_MASK = 8'h00;
    // vector map: 3 bits per source, intx A-D then gpio 0-3
    localparam logic [23:0] RST_VEC_MAP = 24'hFA_C688;
    // arbitrary neutral requester identity
    localparam logic [15:0] RST_REQ_ID = 16'h0100;
    // message kinds
    localparam logic [1:0] KIND_ASSERT = 2'h0;
    localparam logic [1:0] KIND_DEASSERT = 2'h1;
    localparam logic [1:0] KIND_MSI = 2'h2;
endpackage

// file: src/bimg_top.sv
`timescale 1ns/1ps
module bimg_top (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic [bimg_pkg::NUM_INTX-1:0] i_intx_n,
    input wire logic [bimg_pkg::NUM_GPIO-1:0] i_gpio,
    input wire logic i_tgt_post_busy,
    input wire logic i_tgt_post_start,
    input wire logic i_pci_msi_vld,
    input wire logic [63:0] i_pci_msi_addr,
    input wire logic [31:0] i_pci_msi_data,
    input wire logic i_pb_ready,
    input wire logic i_cfg_sel,
    input wire logic i_bar0_hit,
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    output logic o_tgt_retry,
    output logic o_pci_msi_ack,
    output logic o_pb_valid,
    output logic [1:0] o_pb_kind,
    output logic [1:0] o_pb_wire,
    output logic [15:0] o_pb_req_id,
    output logic [63:0] o_pb_addr,
    output logic [31:0] o_pb_data,
    output logic o_irq
);
    import bimg_pkg::*;

    localparam int NSRC = NUM_INTX + NUM_GPIO;

    logic [NUM_INTX-1:0] intx_s1_ff, intx_s2_ff;
    logic [NUM_GPIO-1:0] gpio_s1_ff, gpio_s2_ff, gpio_d_ff;
    logic [NUM_INTX-1:0] rep_ff;
    logic [NUM_INTX-1:0] pend_as_ff, pend_de_ff;
    logic [NSRC-1:0] pend_msi_ff;
    logic [SRC_W-1:0] rr_ff;
    logic [31:0] ctrl_ff;
    logic [7:0] msi_mask_ff;
    logic [23:0] vec_map_ff;
    logic [31:0] msi_addr_ff, msi_data_ff;
    logic [IRQ_W-1:0] irq_stat_ff, irq_mask_ff;
    logic [15:0] req_id_ff;
    logic [31:0] rdata_ff;
    logic retry_ff, ack_ff, pb_vld_ff, irq_ff;
    logic [1:0] kind_ff, wire_ff;
    logic [63:0] addr_ff;
    logic [31:0] data_ff;

    // synchronisers: first stage read only by the second
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            intx_s1_ff <= '1;
            intx_s2_ff <= '1;
            gpio_s1_ff <= '1;
            gpio_s2_ff <= '1;
            gpio_d_ff <= '1;
        end else begin
            intx_s1_ff <= i_intx_n;
            intx_s2_ff <= intx_s1_ff;
            gpio_s1_ff <= i_gpio;
            gpio_s2_ff <= gpio_s1_ff;
            gpio_d_ff <= gpio_s2_ff;
        end
    end

    wire msi_mode = ctrl_ff[CTRL_INTX_MSI];
    wire [NUM_GPIO-1:0] gpio_irq_en = ctrl_ff[CTRL_GPIO_LSB +: NUM_GPIO];
    wire [NUM_INTX-1:0] lvl = ~intx_s2_ff;
    wire [NUM_INTX-1:0] chg = lvl ^ rep_ff;
    wire [NUM_GPIO-1:0] gpio_fall = gpio_d_ff & ~gpio_s2_ff & gpio_irq_en;

    // per-source request: intx pair lines then msi sources
    wire [NUM_INTX-1:0] intx_req = pend_as_ff | pend_de_ff;
    wire [NSRC-1:0] src_req;
    assign src_req[NUM_INTX-1:0] = intx_req | pend_msi_ff[NUM_INTX-1:0];
    assign src_req[NSRC-1:NUM_INTX] = pend_msi_ff[NSRC-1:NUM_INTX];

    // loading allowed only when pci target is idle and buffer ready
    wire load_ok = !i_tgt_post_busy && !i_tgt_post_start && i_pb_ready
        && !pb_vld_ff;

    // round robin search starting after last served source
    logic [SRC_W-1:0] pick;
    logic pick_vld;
    always_comb begin
        logic [SRC_W-1:0] idx;
        pick = '0;
        pick_vld = 1'b0;
        idx = '0;
        for (int k = 1; k <= NSRC; k++) begin
            idx = SRC_W'((int'(rr_ff) + k) % NSRC);
            if (!pick_vld && src_req[idx]) begin
                pick = idx;
                pick_vld = 1'b1;
            end
        end
    end

    wire [SRC_W-1:0] pick_vec = vec_map_ff[pick*SRC_W +: SRC_W];
    wire pick_masked = msi_mask_ff[pick_vec];
    wire pick_is_intx_msg = (pick < SRC_W'(NUM_INTX)) && !msi_mode
        && intx_req[pick[1:0]];
    wire msi_fwd = i_pci_msi_vld && load_ok && !ack_ff;
    wire int_load = load_ok && pick_vld && !msi_fwd;
    wire int_send = int_load && (pick_is_intx_msg || !pick_masked);
    // assert before deassert keeps wires paired
    wire send_as = pick_is_intx_msg && pend_as_ff[pick[1:0]];

    // pending flags: set wins over clear
    logic [NUM_INTX-1:0] nxt_pend_as, nxt_pend_de, nxt_rep;
    logic [NSRC-1:0] nxt_pend_msi;
    always_comb begin
        nxt_pend_as = pend_as_ff;
        nxt_pend_de = pend_de_ff;
        nxt_pend_msi = pend_msi_ff;
        nxt_rep = rep_ff;
        if (int_load) begin
            if (pick_is_intx_msg) begin
                if (send_as) nxt_pend_as[pick[1:0]] = 1'b0;
                else nxt_pend_de[pick[1:0]] = 1'b0;
            end else begin
                nxt_pend_msi[pick] = 1'b0;
            end
        end
        for (int i = 0; i < NUM_INTX; i++) begin
            if (chg[i]) begin
                nxt_rep[i] = lvl[i];
                if (msi_mode) begin
                    if (lvl[i]) nxt_pend_msi[i] = 1'b1;
                end else if (lvl[i]) begin
                    nxt_pend_as[i] = 1'b1;
                end else begin
                    nxt_pend_de[i] = 1'b1;
                end
            end
        end
        for (int g = 0; g < NUM_GPIO; g++)
            if (gpio_fall[g]) nxt_pend_msi[NUM_INTX+g] = 1'b1;
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            rep_ff <= '0;
            pend_as_ff <= '0;
            pend_de_ff <= '0;
            pend_msi_ff <= '0;
            rr_ff <= SRC_W'(NSRC - 1);
        end else begin
            rep_ff <= nxt_rep;
            pend_as_ff <= nxt_pend_as;
            pend_de_ff <= nxt_pend_de;
            pend_msi_ff <= nxt_pend_msi;
            if (int_load) rr_ff <= pick;
        end
    end

    // single posted buffer port for messages and msi writes
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            pb_vld_ff <= 1'b0;
            kind_ff <= KIND_ASSERT;
            wire_ff <= '0;
            addr_ff <= '0;
            data_ff <= '0;
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= msi_fwd;
            if (msi_fwd) begin
                pb_vld_ff <= 1'b1;
                kind_ff <= KIND_MSI;
                addr_ff <= i_pci_msi_addr;
                data_ff <= i_pci_msi_data;
            end else if (int_send) begin
                pb_vld_ff <= 1'b1;
                if (pick_is_intx_msg) begin
                    kind_ff <= send_as ? KIND_ASSERT : KIND_DEASSERT;
                    wire_ff <= pick[1:0];
                end else begin
                    kind_ff <= KIND_MSI;
                    addr_ff <= {32'h0000_0000, msi_addr_ff};
                    data_ff <= {msi_data_ff[31:SRC_W], pick_vec};
                end
            end else if (i_pb_ready) begin
                pb_vld_ff <= 1'b0;
            end
        end
    end

    // retry pci posted writes while an internal message is in flight
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) retry_ff <= 1'b0;
        else retry_ff <= int_load || (pb_vld_ff && kind_ff != KIND_MSI);
    end

    // register port: config or bar0 window hits reach the msi registers
    wire acc = i_cfg_sel || i_bar0_hit;
    wire wr = i_reg_wr && acc;
    wire rd = i_reg_rd && acc;
    wire sel_ctrl = (i_reg_addr == REG_CTRL);
    wire sel_mask = (i_reg_addr == REG_MSI_MASK);
    wire sel_map = (i_reg_addr == REG_VEC_MAP);
    wire sel_maddr = (i_reg_addr == REG_MSI_ADDR);
    wire sel_mdata = (i_reg_addr == REG_MSI_DATA);
    wire sel_pin = (i_reg_addr == REG_PIN_STAT);
    wire sel_ist = (i_reg_addr == REG_IRQ_STAT);
    wire sel_imask = (i_reg_addr == REG_IRQ_MASK);
    wire sel_rid = (i_reg_addr == REG_REQ_ID);
    logic [31:0] rd_mux;
    always_comb begin
        if (sel_ctrl) rd_mux = ctrl_ff;
        else if (sel_mask) rd_mux = {24'h00_0000, msi_mask_ff};
        else if (sel_map) rd_mux = {8'h00, vec_map_ff};
        else if (sel_maddr) rd_mux = msi_addr_ff;
        else if (sel_mdata) rd_mux = msi_data_ff;
        else if (sel_pin) rd_mux = {20'h0_0000, pend_de_ff, pend_as_ff,
            rep_ff};
        else if (sel_ist) rd_mux = {30'h0000_0000, irq_stat_ff};
        else if (sel_imask) rd_mux = {30'h0000_0000, irq_mask_ff};
        else if (sel_rid) rd_mux = {16'h0000, req_id_ff};
        else rd_mux = 32'h0000_0000;
    end

    wire [IRQ_W-1:0] irq_ev = {int_load && !int_send, int_send};
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_ff <= RST_CTRL;
            msi_mask_ff <= RST_MSI_MASK;
            vec_map_ff <= RST_VEC_MAP;
            msi_addr_ff <= '0;
            msi_data_ff <= '0;
            irq_mask_ff <= '0;
            req_id_ff <= RST_REQ_ID;
        end else if (wr) begin
            if (sel_ctrl) ctrl_ff <= i_reg_wdata;
            if (sel_mask) msi_mask_ff <= i_reg_wdata[7:0];
            if (sel_map) vec_map_ff <= i_reg_wdata[23:0];
            if (sel_maddr) msi_addr_ff <= i_reg_wdata;
            if (sel_mdata) msi_data_ff <= i_reg_wdata;
            if (sel_imask) irq_mask_ff <= i_reg_wdata[IRQ_W-1:0];
            if (sel_rid) req_id_ff <= i_reg_wdata[15:0];
        end
    end

    // status: event set beats write-one clear
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_stat_ff <= '0;
            irq_ff <= 1'b0;
            rdata_ff <= '0;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~((wr && sel_ist) ?
                i_reg_wdata[IRQ_W-1:0] : {IRQ_W{1'b0}})) | irq_ev;
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
            rdata_ff <= rd ? rd_mux : 32'h0000_0000;
        end
    end

    assign o_reg_rdata = rdata_ff;
    assign o_tgt_retry = retry_ff;
    assign o_pci_msi_ack = ack_ff;
    assign o_pb_valid = pb_vld_ff;
    assign o_pb_kind = kind_ff;
    assign o_pb_wire = wire_ff;
    assign o_pb_req_id = req_id_ff;
    assign o_pb_addr = addr_ff;
    assign o_pb_data = data_ff;
    assign o_irq = irq_ff;
endmodule // bimg_top

// file: verif/bimg_pb_model.sv
`timescale 1ns/1ps
module bimg_pb_model (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_slow,
    output logic o_ready
);
    // slow mode stalls about two cycles in three
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_ready <= 1'b0;
        end else begin
            o_ready <= !i_slow || ($urandom % 3 == 0);
        end
    end
endmodule // bimg_pb_model

// file: verif/bimg_top_bench.sv
`timescale 1ns/1ps
module bimg_top_bench;
    import bimg_pkg::*;
    logic i_mclk = 0, i_nrst = 0, i_tgt_post_busy = 0, i_tgt_post_start = 0;
    logic [3:0] i_intx_n = 4'hF, i_gpio = 4'hF;
    logic i_pci_msi_vld = 0, i_pb_ready, i_cfg_sel = 1, i_bar0_hit = 0;
    logic [63:0] i_pci_msi_addr = 0, o_pb_addr;
    logic [31:0] i_pci_msi_data = 0, i_reg_wdata = 0, o_reg_rdata, o_pb_data;
    logic [7:0] i_reg_addr = 0;
    logic i_reg_wr = 0, i_reg_rd = 0, o_tgt_retry, o_pci_msi_ack;
    logic o_pb_valid, o_irq, slow = 1;
    logic [1:0] o_pb_kind, o_pb_wire, k, w;
    logic [15:0] o_pb_req_id;
    logic [31:0] d, a;
    logic [3:0] seen;
    int bad_count = 0, cmp_count = 0, cyc = 0;
    bimg_top uut (.*);
    bimg_pb_model pb (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_slow(slow),
        .o_ready(i_pb_ready));
    always #4 i_mclk = ~i_mclk;
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            give_verdict();
        end
    end
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("Error at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
        @(posedge i_mclk);
        i_reg_addr <= ad;
        i_reg_wdata <= dt;
        i_reg_wr <= 1'b1;
        @(posedge i_mclk);
        i_reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] e);
        @(posedge i_mclk);
        i_reg_addr <= ad;
        i_reg_rd <= 1'b1;
        @(posedge i_mclk);
        i_reg_rd <= 1'b0;
        #1 chk(o_reg_rdata, e);
    endtask
    task automatic get();
        int n;
        n = 0;
        do begin
            @(negedge i_mclk);
            n++;
        end while (!(o_pb_valid && i_pb_ready) && n < 200);
        chk(o_pb_valid, 1'b1);
        k = o_pb_kind;
        w = o_pb_wire;
        d = o_pb_data;
        a = o_pb_addr[31:0];
        @(posedge i_mclk);
        i_pci_msi_vld <= 1'b0;
    endtask
    task automatic none(input int n);
        repeat (n) @(negedge i_mclk) chk(o_pb_valid, 1'b0);
    endtask
    task automatic grp(input logic [1:0] ek);
        seen = 4'h0;
        repeat (4) begin
            get();
            chk(k, ek);
            seen[w] = 1'b1;
        end
        chk(seen, 4'hF);
    endtask
    initial begin
        void'($urandom(32'h57101b60));
        repeat (6) @(posedge i_mclk);
        i_nrst <= 1'b1;
        @(posedge i_mclk);
        chk(o_pb_req_id, RST_REQ_ID);
        rd(REG_CTRL, RST_CTRL);
        rd(REG_VEC_MAP, {8'h00, RST_VEC_MAP});
        rd(8'hFC, 32'h0000_0000);
        i_cfg_sel <= 1'b0;
        wr(REG_MSI_MASK, 32'h0000_00FF);
        i_bar0_hit <= 1'b1;
        rd(REG_MSI_MASK, 32'h0000_0000);
        wr(REG_MSI_MASK, 32'h0000_0010);
        i_bar0_hit <= 1'b0;
        i_cfg_sel <= 1'b1;
        rd(REG_MSI_MASK, 32'h0000_0010);
        for (int i = 0; i < 4; i++) begin
            i_intx_n[i] <= 1'b0;
            get();
            chk(k, KIND_ASSERT);
            chk(w, 64'(i));
            i_intx_n[i] <= 1'b1;
            get();
            chk(k, KIND_DEASSERT);
            chk(w, 64'(i));
        end
        i_intx_n <= 4'h0;
        grp(KIND_ASSERT);
        i_intx_n <= 4'hF;
        grp(KIND_DEASSERT);
        i_tgt_post_busy <= 1'b1;
        i_tgt_post_start <= 1'b1;
        i_intx_n[2] <= 1'b0;
        @(posedge i_mclk);
        i_tgt_post_start <= 1'b0;
        none(10);
        i_tgt_post_busy <= 1'b0;
        get();
        chk(w, 2'd2);
        i_intx_n[2] <= 1'b1;
        get();
        slow <= 1'b0;
        repeat (4) begin
            @(posedge i_mclk);
            i_pci_msi_addr <= {$urandom, $urandom};
            i_pci_msi_data <= $urandom;
            i_pci_msi_vld <= 1'b1;
            get();
            chk(k, KIND_MSI);
            chk(d, i_pci_msi_data);
        end
        slow <= 1'b1;
        wr(REG_MSI_DATA, 32'h1234_5670);
        wr(REG_MSI_ADDR, 32'hFEE0_0000);
        wr(REG_CTRL, 32'h0000_00F0);
        wr(REG_IRQ_MASK, 32'h0000_0000);
        wr(REG_IRQ_STAT, 32'h0000_0003);
        i_gpio[1] <= 1'b0;
        get();
        chk({k, d, a}, {KIND_MSI, 32'h1234_5675, 32'hFEE0_0000});
        i_gpio[1] <= 1'b1;
        none(8);
        i_gpio[0] <= 1'b0;
        none(8);
        rd(REG_IRQ_STAT, 32'h0000_0003);
        chk(o_irq, 1'b0);
        wr(REG_IRQ_MASK, 32'h0000_0001);
        rd(REG_IRQ_STAT, 32'h0000_0003);
        chk(o_irq, 1'b1);
        wr(REG_IRQ_STAT, 32'h0000_0001);
        rd(REG_IRQ_STAT, 32'h0000_0002);
        chk(o_irq, 1'b0);
        i_gpio[0] <= 1'b1;
        wr(REG_CTRL, 32'h0000_0001);
        i_intx_n[3] <= 1'b0;
        get();
        chk({k, d}, {KIND_MSI, 32'h1234_5673});
        i_intx_n[3] <= 1'b1;
        none(8);
        give_verdict();
    end
endmodule // bimg_top_bench

// file: verif/bimg_top_checker.sv
`timescale 1ns/1ps
module bimg_top_checker import bimg_pkg::*; (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_tgt_post_busy,
    input wire logic i_pci_msi_vld,
    input wire logic [63:0] i_pci_msi_addr,
    input wire logic [31:0] i_pci_msi_data,
    input wire logic i_pb_ready,
    input wire logic i_reg_rd,
    input logic [31:0] o_reg_rdata,
    input logic o_tgt_retry,
    input logic o_pci_msi_ack,
    input logic o_pb_valid,
    input logic [1:0] o_pb_kind,
    input logic [1:0] o_pb_wire,
    input logic [63:0] o_pb_addr,
    input logic [31:0] o_pb_data
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    logic [3:0] up_ff;
    logic [3:0] nxt_up;
    wire taken = o_pb_valid && i_pb_ready;
    always_comb begin
        nxt_up = up_ff;
        if (taken && o_pb_kind == KIND_ASSERT) nxt_up[o_pb_wire] = 1'b1;
        if (taken && o_pb_kind == KIND_DEASSERT) nxt_up[o_pb_wire] = 1'b0;
    end
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) up_ff <= '0;
        else up_ff <= nxt_up;
    end
    sequence s_taken;
        o_pb_valid && i_pb_ready;
    endsequence
    sequence s_load;
        $rose(o_pb_valid) && o_pb_kind != KIND_MSI;
    endsequence
    property p_hold;
        o_pb_valid && !i_pb_ready |=> o_pb_valid && $stable(o_pb_kind)
            && $stable(o_pb_wire) && $stable(o_pb_data);
    endproperty
    a_hold: assert property (p_hold) else $error("entry dropped");
    property p_ready;
        $rose(o_pb_valid) |-> $past(i_pb_ready);
    endproperty
    a_ready: assert property (p_ready) else $error("load unready");
    property p_retry;
        s_load |-> o_tgt_retry;
    endproperty
    a_retry: assert property (p_retry) else $error("no retry");
    property p_stall;
        i_tgt_post_busy && !i_pci_msi_vld |=> !$rose(o_pb_valid);
    endproperty
    a_stall: assert property (p_stall) else $error("load in busy");
    property p_seven;
        s_taken ##0 (o_pb_kind == KIND_ASSERT) |-> !up_ff[o_pb_wire];
    endproperty
    a_seven: assert property (p_seven) else $error("double assert");
    property p_fwd;
        o_pci_msi_ack |-> o_pb_valid && o_pb_kind == KIND_MSI
            && o_pb_addr == i_pci_msi_addr && o_pb_data == i_pci_msi_data;
    endproperty
    a_fwd: assert property (p_fwd) else $error("msi fwd wrong");
    property p_ack;
        o_pci_msi_ack |-> $past(i_pci_msi_vld) ##1 !o_pci_msi_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("bad ack");
    property p_kind;
        o_pb_valid |-> o_pb_kind != 2'h3;
    endproperty
    a_kind: assert property (p_kind) else $error("bad kind");
    property p_rdata;
        !$past(i_reg_rd) |-> o_reg_rdata == 32'h0000_0000;
    endproperty
    a_rdata: assert property (p_rdata) else $error("stray rdata");
endmodule // bimg_top_checker
bind bimg_top bimg_top_checker chk (.*);
